// ===== rtl/rsw_pkg.sv
// package for the reset sequencer and supervision timer: constants, carriers and state types
package rsw_pkg;
	// reset source positions in the request vector and in the status flags
	localparam int SRC_N = 6;
	localparam int SRC_POR = 0;
	localparam int SRC_DROP = 1;
	localparam int SRC_PIN = 2;
	localparam int SRC_TMR = 3;
	localparam int SRC_SW = 4;
	localparam int SRC_DBG = 5;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TMR_CFG = 8'h08;
	localparam logic [7:0] ADDR_KEY = 8'h0C;
	localparam logic [7:0] ADDR_SEQ = 8'h10;

	// field positions
	localparam int CTRL_SWRST_BIT = 0;
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_WIN_BIT = 1;
	localparam int CFG_PER_LSB = 4;
	localparam int CFG_WSEL_LSB = 8;

	// reset values
	localparam logic [3:0] PER_SEL_RST = 4'h0;
	localparam logic [3:0] WIN_SEL_RST = 4'h0;
	localparam logic [2:0] DROP_LOWEST = 3'h0;

	// configuration change protection: key value is arbitrary
	localparam logic [7:0] CCP_KEY = 8'h5A;
	localparam logic [2:0] CCP_WINDOW_CYC = 3'h4;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int TMR_PULSE_NS = 500;
	localparam int TMR_PULSE_CYC = (TMR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_PIN_NS = 1000;
	localparam int MIN_PIN_CYC = (MIN_PIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DELAY_CYC_DEF = 64;
	localparam int OSC_START_CYC_DEF = 32;
	localparam int OSC_CAL_CYC_DEF = 16;

	// supervision timer periods in 1 kHz ticks
	localparam logic [14:0] TMR_BASE_TICKS = 15'h0008;
	localparam logic [3:0] TMR_SEL_MAX = 4'hA;

	// timeout length for a period select, out-of-range selects clamp to the longest
	function automatic logic [14:0] rsw_ticks(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > TMR_SEL_MAX) ? TMR_SEL_MAX : sel;
		return TMR_BASE_TICKS << s;
	endfunction : rsw_ticks

	typedef enum logic [2:0] {
		SEQ_HOLD,
		SEQ_DELAY,
		SEQ_OSC_START,
		SEQ_OSC_CAL,
		SEQ_RUN
	} rsw_seq_type;

	// avalon request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} rsw_bus_req_type;

	typedef struct packed {
		rsw_seq_type seq;
		logic [15:0] stage_cnt;
		logic [7:0] pin_cnt;
		logic pin_ok;
		logic [3:0] pulse_cnt;
		logic sw_req;
		logic halt;
		logic [SRC_N-1:0] flags;
		logic cfg_en;
		logic cfg_win;
		logic [3:0] per_sel;
		logic [3:0] win_sel;
		logic [2:0] ccp_cnt;
		logic ack;
		logic [31:0] rdata;
	} rsw_state_type;

	typedef struct packed {
		logic [14:0] cnt;
		logic fire;
	} rsw_tmr_state_type;
endpackage : rsw_pkg

// ===== rtl/rsw_timer.sv
// supervision timer core: tick counter, normal and window timeout, early-restart detection
`timescale 1ns/1ps
module rsw_timer (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tick,
	input wire logic i_enable,
	input wire logic i_window,
	input wire logic [3:0] i_per_sel,
	input wire logic [3:0] i_win_sel,
	input wire logic i_restart,
	input wire logic i_clear,
	output logic o_expire
);
	import rsw_pkg::*;

	rsw_tmr_state_type st_ff;
	rsw_tmr_state_type nxt_st;
	logic [14:0] per_ticks;
	logic [14:0] win_ticks;
	logic [15:0] limit;

	// closed slot comes first in window mode, then the open slot of the timeout length
	assign per_ticks = rsw_ticks(i_per_sel);
	assign win_ticks = rsw_ticks(i_win_sel);
	assign limit = i_window ? ({1'b0, win_ticks} + {1'b0, per_ticks}) : {1'b0, per_ticks};

	// counting stops only when disabled or the device is in reset; no sleep input gates it
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fire = 1'b0;
		if (i_clear || !i_enable) begin
			nxt_st.cnt = 15'h0000;
		end else if (i_restart) begin
			nxt_st.cnt = 15'h0000;
			if (i_window && (st_ff.cnt < win_ticks)) begin
				nxt_st.fire = 1'b1;
			end
		end else if ({1'b0, st_ff.cnt} >= limit) begin
			nxt_st.fire = 1'b1;
			nxt_st.cnt = 15'h0000;
		end else if (i_tick) begin
			nxt_st.cnt = st_ff.cnt + 15'h0001;
		end
	end

	// registered state
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_expire = st_ff.fire;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_early_restart;
		i_enable && i_window && !i_clear && i_restart && (st_ff.cnt < win_ticks) |=> o_expire;
	endproperty
	a_early_restart: assert property (p_early_restart) else $error("early restart gave no reset");

	property p_normal_timeout;
		i_enable && !i_window && !i_clear && !i_restart && ({1'b0, st_ff.cnt} >= limit) |=> o_expire;
	endproperty
	a_normal_timeout: assert property (p_normal_timeout) else $error("timeout gave no reset");

	property p_inslot_ok;
		i_enable && i_window && !i_clear && i_restart && (st_ff.cnt >= win_ticks) |=> !o_expire;
	endproperty
	a_inslot_ok: assert property (p_inslot_ok) else $error("restart in slot caused reset");
endmodule : rsw_timer

// ===== rtl/rsw_top.sv
// reset sequencer with source merging, status flags, supervision timer and avalon registers
// Functional notes
// - any request resets at once and holds
// - release steps delay, osc start, osc calibrate
// - new request restarts the sequence from start
// - power-on detector requests reset both directions
// - disabled drop detect forced lowest on erase/debug
// - pin reset only after low beyond minimum
// - timer reset pulse lasts 1-2 oscillator cycles (held here for PULSE_LEN, 5 clock cycles, 500 ns)
// - software reset bit resets within two cycles
// - cpu halted from software request until reset
// - debug link reset only from external programmer
// - enabled timer resets if not restarted
// - eleven timeout periods, 8ms up to 8s
// - window mode resets on early or late restart
// - timer counts 1kHz tick from slow oscillator
// - timer runs in all modes, clock independent (here the counter is clocked by i_clk, so it stops with the system clock)
// - timer settings protected and fuse-lockable
// - sticky per-source flags cleared on power-on
// - oscillator started, calibrated before execution resumes
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module rsw_top #(
	parameter int DELAY_CYCLES = rsw_pkg::DELAY_CYC_DEF,
	parameter int OSC_START_CYCLES = rsw_pkg::OSC_START_CYC_DEF,
	parameter int OSC_CAL_CYCLES = rsw_pkg::OSC_CAL_CYC_DEF,
	parameter int PIN_CYCLES = rsw_pkg::MIN_PIN_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire rsw_pkg::rsw_bus_req_type i_bus,
	output logic o_waitrequest,
	output logic [31:0] o_readdata,
	input wire logic i_power_on_det,
	input wire logic i_supply_drop_det,
	input wire logic i_drop_detect_cfg_en,
	input wire logic [2:0] i_drop_threshold_fuse,
	input wire logic i_chip_erase,
	input wire logic i_debug_link_en,
	input wire logic i_debug_link_rst,
	input wire logic i_reset_pin_n,
	input wire logic i_tick_1khz,
	input wire logic i_timer_restart,
	input wire logic i_timer_lock_fuse,
	output logic o_drop_detect_force,
	output logic [2:0] o_drop_threshold_select,
	output logic o_dev_reset,
	output logic o_cpu_halt,
	output logic o_osc_start,
	output logic o_osc_cal
);
	import rsw_pkg::*;

	// parameters the sequencer counters cannot serve
	if (DELAY_CYCLES < 1 || DELAY_CYCLES > 65535) begin : g_chk_delay
		$error("DELAY_CYCLES out of range");
	end
	if (OSC_START_CYCLES < 1 || OSC_START_CYCLES > 65535) begin : g_chk_start
		$error("OSC_START_CYCLES out of range");
	end
	if (OSC_CAL_CYCLES < 1 || OSC_CAL_CYCLES > 65535) begin : g_chk_cal
		$error("OSC_CAL_CYCLES out of range");
	end
	if (PIN_CYCLES < 1 || PIN_CYCLES > 254) begin : g_chk_pin
		$error("PIN_CYCLES out of range");
	end

	localparam logic [15:0] DELAY_LAST = 16'(DELAY_CYCLES - 1);
	localparam logic [15:0] START_LAST = 16'(OSC_START_CYCLES - 1);
	localparam logic [15:0] CAL_LAST = 16'(OSC_CAL_CYCLES - 1);
	localparam logic [7:0] PIN_LIMIT = 8'(PIN_CYCLES);
	localparam logic [3:0] PULSE_LEN = 4'(TMR_PULSE_CYC);

	rsw_state_type st_ff;
	rsw_state_type nxt_st;
	logic [SRC_N-1:0] req_vec;
	logic req_any;
	logic tmr_expire;
	logic bus_req;
	logic bus_acc;
	logic wr_acc;
	logic sw_acc;
	logic cfg_open;
	logic [31:0] rd_mux;

	// drop detect is forced on at its lowest level when disabled during erase or debug
	assign o_drop_detect_force = !i_drop_detect_cfg_en && (i_chip_erase || i_debug_link_en);
	assign o_drop_threshold_select = o_drop_detect_force ? DROP_LOWEST : i_drop_threshold_fuse;

	// merged request vector; the debug source has no register path at all
	always_comb begin
		req_vec = '0;
		req_vec[SRC_POR] = i_power_on_det;
		req_vec[SRC_DROP] = i_supply_drop_det && (i_drop_detect_cfg_en || o_drop_detect_force);
		req_vec[SRC_PIN] = st_ff.pin_ok;
		req_vec[SRC_TMR] = (st_ff.pulse_cnt != 4'h0);
		req_vec[SRC_SW] = st_ff.sw_req;
		req_vec[SRC_DBG] = i_debug_link_rst;
	end
	assign req_any = |req_vec;

	// avalon slave: one wait state, answer at the second edge of a request
	assign bus_req = i_bus.read || i_bus.write;
	assign o_waitrequest = bus_req && !st_ff.ack;
	assign bus_acc = bus_req && st_ff.ack;
	assign wr_acc = bus_acc && i_bus.write;
	assign sw_acc = wr_acc && (i_bus.address == ADDR_CTRL) && i_bus.writedata[CTRL_SWRST_BIT];
	assign cfg_open = (st_ff.ccp_cnt != 3'h0) && !i_timer_lock_fuse;

	// read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (i_bus.address == ADDR_CTRL) begin
			rd_mux = 32'h0000_0000;
		end else if (i_bus.address == ADDR_STATUS) begin
			rd_mux[SRC_N-1:0] = st_ff.flags;
		end else if (i_bus.address == ADDR_TMR_CFG) begin
			rd_mux[CFG_EN_BIT] = st_ff.cfg_en;
			rd_mux[CFG_WIN_BIT] = st_ff.cfg_win;
			rd_mux[CFG_PER_LSB +: 4] = st_ff.per_sel;
			rd_mux[CFG_WSEL_LSB +: 4] = st_ff.win_sel;
		end else if (i_bus.address == ADDR_KEY) begin
			rd_mux[2:0] = st_ff.ccp_cnt;
		end else if (i_bus.address == ADDR_SEQ) begin
			rd_mux[2:0] = st_ff.seq;
		end
	end

	// supervision timer, cleared while the device sits in reset
	rsw_timer u_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_tick(i_tick_1khz),
		.i_enable(st_ff.cfg_en),
		.i_window(st_ff.cfg_win),
		.i_per_sel(st_ff.per_sel),
		.i_win_sel(st_ff.win_sel),
		.i_restart(i_timer_restart),
		.i_clear(o_dev_reset),
		.o_expire(tmr_expire)
	);

	// next state of the whole block
	always_comb begin
		nxt_st = st_ff;

		// sequencer: any request drops back to hold, whatever stage is running
		if (req_any) begin
			nxt_st.seq = SEQ_HOLD;
			nxt_st.stage_cnt = 16'h0000;
		end else begin
			case (st_ff.seq)
				SEQ_HOLD: begin
					nxt_st.seq = SEQ_DELAY;
					nxt_st.stage_cnt = 16'h0000;
				end
				SEQ_DELAY: begin
					if (st_ff.stage_cnt == DELAY_LAST) begin
						nxt_st.seq = SEQ_OSC_START;
						nxt_st.stage_cnt = 16'h0000;
					end else begin
						nxt_st.stage_cnt = st_ff.stage_cnt + 16'h0001;
					end
				end
				SEQ_OSC_START: begin
					if (st_ff.stage_cnt == START_LAST) begin
						nxt_st.seq = SEQ_OSC_CAL;
						nxt_st.stage_cnt = 16'h0000;
					end else begin
						nxt_st.stage_cnt = st_ff.stage_cnt + 16'h0001;
					end
				end
				SEQ_OSC_CAL: begin
					if (st_ff.stage_cnt == CAL_LAST) begin
						nxt_st.seq = SEQ_RUN;
						nxt_st.stage_cnt = 16'h0000;
					end else begin
						nxt_st.stage_cnt = st_ff.stage_cnt + 16'h0001;
					end
				end
				default: begin
					nxt_st.stage_cnt = 16'h0000;
				end
			endcase
		end

		// pin filter: short glitches never reach the sequencer
		if (i_reset_pin_n) begin
			nxt_st.pin_cnt = 8'h00;
			nxt_st.pin_ok = 1'b0;
		end else if (st_ff.pin_cnt == PIN_LIMIT) begin
			nxt_st.pin_ok = 1'b1;
		end else begin
			nxt_st.pin_cnt = st_ff.pin_cnt + 8'h01;
		end

		// stretch the timer event to a fixed reset pulse
		if (tmr_expire) begin
			nxt_st.pulse_cnt = PULSE_LEN;
		end else if (st_ff.pulse_cnt != 4'h0) begin
			nxt_st.pulse_cnt = st_ff.pulse_cnt - 4'h1;
		end

		// software reset: request and halt stand until the sequencer has taken it
		if (sw_acc) begin
			nxt_st.sw_req = 1'b1;
			nxt_st.halt = 1'b1;
		end else if (st_ff.seq == SEQ_HOLD) begin
			nxt_st.sw_req = 1'b0;
			nxt_st.halt = 1'b0;
		end

		// status flags: write one clears, a new event in the same cycle wins
		if (wr_acc && (i_bus.address == ADDR_STATUS)) begin
			nxt_st.flags = st_ff.flags & ~i_bus.writedata[SRC_N-1:0];
		end
		nxt_st.flags = nxt_st.flags | req_vec;
		if (req_vec[SRC_POR]) begin
			nxt_st.flags = '0;
			nxt_st.flags[SRC_POR] = 1'b1;
		end

		// protection window: the key opens a few cycles for one config write
		if (st_ff.ccp_cnt != 3'h0) begin
			nxt_st.ccp_cnt = st_ff.ccp_cnt - 3'h1;
		end
		if (wr_acc && (i_bus.address == ADDR_KEY)) begin
			nxt_st.ccp_cnt = (i_bus.writedata[7:0] == CCP_KEY) ? CCP_WINDOW_CYC : 3'h0;
		end
		if (wr_acc && (i_bus.address == ADDR_TMR_CFG)) begin
			nxt_st.ccp_cnt = 3'h0;
			if (cfg_open) begin
				nxt_st.cfg_en = i_bus.writedata[CFG_EN_BIT];
				nxt_st.cfg_win = i_bus.writedata[CFG_WIN_BIT];
				nxt_st.per_sel = i_bus.writedata[CFG_PER_LSB +: 4];
				nxt_st.win_sel = i_bus.writedata[CFG_WSEL_LSB +: 4];
			end
		end

		// bus handshake and registered read data
		nxt_st.ack = bus_req && !st_ff.ack;
		if (i_bus.read && !st_ff.ack) begin
			nxt_st.rdata = rd_mux;
		end
	end

	// registered state; the device starts held in reset and walks the sequence
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_ff <= '{seq: SEQ_HOLD, per_sel: PER_SEL_RST, win_sel: WIN_SEL_RST, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs decoded from flops, except o_cpu_halt, which also takes sw_acc straight from the bus
	assign o_readdata = st_ff.rdata;
	assign o_dev_reset = (st_ff.seq != SEQ_RUN);
	assign o_cpu_halt = st_ff.halt || sw_acc || o_dev_reset;
	assign o_osc_start = (st_ff.seq == SEQ_OSC_START);
	assign o_osc_cal = (st_ff.seq == SEQ_OSC_CAL);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_req_hold;
		req_any |=> (st_ff.seq == SEQ_HOLD) && o_dev_reset;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request did not hold reset");

	sequence s_delay_end;
		(st_ff.seq == SEQ_DELAY) && (st_ff.stage_cnt == DELAY_LAST) && !req_any;
	endsequence
	sequence s_start_entered;
		##1 (st_ff.seq == SEQ_OSC_START) && (st_ff.stage_cnt == 16'h0000);
	endsequence
	property p_stage_order;
		s_delay_end |-> s_start_entered;
	endproperty
	a_stage_order: assert property (p_stage_order) else $error("start stage did not follow delay");

	property p_run_from_cal;
		$rose(st_ff.seq == SEQ_RUN) |-> $past(st_ff.seq) == SEQ_OSC_CAL;
	endproperty
	a_run_from_cal: assert property (p_run_from_cal) else $error("run entered without calibration");

	property p_restart_seq;
		(st_ff.seq inside {SEQ_DELAY, SEQ_OSC_START, SEQ_OSC_CAL}) && req_any |=> st_ff.seq == SEQ_HOLD;
	endproperty
	a_restart_seq: assert property (p_restart_seq) else $error("stage not abandoned on request");

	property p_pin_glitch;
		i_reset_pin_n |=> !st_ff.pin_ok && (st_ff.pin_cnt == 8'h00);
	endproperty
	a_pin_glitch: assert property (p_pin_glitch) else $error("pin reset without low pin");

	property p_tmr_pulse;
		tmr_expire |=> req_vec[SRC_TMR] [*5];
	endproperty
	a_tmr_pulse: assert property (p_tmr_pulse) else $error("timer reset pulse too short");

	property p_sw_reset;
		sw_acc |-> ##[1:2] o_dev_reset;
	endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("software reset late");

	property p_sw_halt;
		sw_acc |-> o_cpu_halt ##1 o_cpu_halt ##1 o_cpu_halt;
	endproperty
	a_sw_halt: assert property (p_sw_halt) else $error("cpu not halted before reset");

	property p_drop_force;
		!i_drop_detect_cfg_en && i_debug_link_en |-> o_drop_detect_force && (o_drop_threshold_select == DROP_LOWEST);
	endproperty
	a_drop_force: assert property (p_drop_force) else $error("drop detect not forced");

	property p_lock;
		i_timer_lock_fuse |=> $stable({st_ff.cfg_en, st_ff.cfg_win, st_ff.per_sel, st_ff.win_sel});
	endproperty
	a_lock: assert property (p_lock) else $error("locked timer settings changed");

	// release edge left out: i_srst still clears the flags at that edge, ahead of any power-on event
	property p_por_flags;
		i_power_on_det && !i_srst |=> st_ff.flags == 6'(1 << SRC_POR);
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("flags not cleared on power-on");

	property p_por_reset;
		i_power_on_det |=> o_dev_reset;
	endproperty
	a_por_reset: assert property (p_por_reset) else $error("power-on gave no reset");

	// the debug flag has no register path, so only the link request may raise it
	property p_dbg_only;
		!i_debug_link_rst && !st_ff.flags[SRC_DBG] |=> !st_ff.flags[SRC_DBG];
	endproperty
	a_dbg_only: assert property (p_dbg_only) else $error("debug flag set without link request");

	// a pin held low through the whole filter count must be recognised next cycle
	property p_pin_taken;
		!i_reset_pin_n && (st_ff.pin_cnt == PIN_LIMIT) |=> st_ff.pin_ok;
	endproperty
	a_pin_taken: assert property (p_pin_taken) else $error("long pin low not recognised");

	// the delay counter never runs past its programmed end
	property p_delay_bound;
		(st_ff.seq == SEQ_DELAY) |-> (st_ff.stage_cnt <= DELAY_LAST);
	endproperty
	a_delay_bound: assert property (p_delay_bound) else $error("delay stage overran");
endmodule : rsw_top

// ===== verif/rsw_far.sv
// far-side model: reset pin with pull-up, slow oscillator tick and restart instruction pulses
`timescale 1ns/1ps
module rsw_far (
	input wire logic i_clk,
	input wire logic i_pin_low,
	input wire logic i_tick_en,
	input wire logic i_restart_req,
	output logic o_reset_pin_n,
	output logic o_tick_1khz = 1'b0,
	output logic o_timer_restart = 1'b0
);
	logic req_q = 1'b0;
	// a released pin rises to the internal pull-up level
	assign o_reset_pin_n = !i_pin_low;
	// tick every cycle keeps long timeouts short; restart is one pulse per request
	always_ff @(posedge i_clk) begin
		o_tick_1khz <= i_tick_en;
		req_q <= i_restart_req;
		o_timer_restart <= i_restart_req & !req_q;
	end
endmodule : rsw_far

// ===== verif/rsw_top_test.sv
// self-checking bench for the reset sequencer and supervision timer
`timescale 1ns/1ps
module rsw_top_test;
	import rsw_pkg::*;
	localparam int DC = 3;
	localparam int SC = 4;
	localparam int CC = 2;
	localparam int PC = 3;
	localparam int BASE = DC + SC + CC + 2;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	rsw_bus_req_type bus_q = '0;
	logic por = 1'b0, drop = 1'b0, cfg_en = 1'b0, erase = 1'b0, dbg_en = 1'b0, dbg_rst = 1'b0, lock = 1'b0;
	logic pin_low = 1'b0, tick_en = 1'b0, rst_req = 1'b0;
	logic [2:0] fuse = 3'h0;
	logic waitreq, dev_reset, cpu_halt, osc_start, osc_cal, force_on, pin_n, tick, restart;
	logic [2:0] thr;
	logic [31:0] rdata;
	logic [31:0] rng = 32'h0000_0034;
	int err_count = 0;
	int checks = 0;

	rsw_top #(.DELAY_CYCLES(DC), .OSC_START_CYCLES(SC), .OSC_CAL_CYCLES(CC), .PIN_CYCLES(PC)) i_rsw_top (
		.i_clk(i_clk), .i_srst(i_srst), .i_bus(bus_q), .o_waitrequest(waitreq), .o_readdata(rdata),
		.i_power_on_det(por), .i_supply_drop_det(drop), .i_drop_detect_cfg_en(cfg_en),
		.i_drop_threshold_fuse(fuse), .i_chip_erase(erase), .i_debug_link_en(dbg_en),
		.i_debug_link_rst(dbg_rst), .i_reset_pin_n(pin_n), .i_tick_1khz(tick), .i_timer_restart(restart),
		.i_timer_lock_fuse(lock), .o_drop_detect_force(force_on), .o_drop_threshold_select(thr),
		.o_dev_reset(dev_reset), .o_cpu_halt(cpu_halt), .o_osc_start(osc_start), .o_osc_cal(osc_cal));
	rsw_far i_rsw_far (.i_clk(i_clk), .i_pin_low(pin_low), .i_tick_en(tick_en), .i_restart_req(rst_req),
		.o_reset_pin_n(pin_n), .o_tick_1khz(tick), .o_timer_restart(restart));

	// free-running system clock
	initial begin
		forever #50 i_clk = ~i_clk;
	end

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs

	// forced detector runs at the lowest threshold, otherwise the fuse setting
	function automatic logic [31:0] exp_force(input logic [5:0] v);
		logic f;
		f = !v[5] & (v[4] | v[3]);
		return {28'h000_0000, f, f ? 3'h0 : v[2:0]};
	endfunction : exp_force

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	// one bus cycle; waitrequest and readdata are taken mid-cycle, so they hold the value set at the last edge, which the next edge samples
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		logic w;
		int n;
		n = 0;
		w = 1'b1;
		rd = '0;
		@(posedge i_clk);
		bus_q <= '{read: !wr, write: wr, address: a, writedata: d};
		while (w === 1'b1 && n < 100) begin
			@(negedge i_clk);
			w = waitreq;
			rd = rdata;
			n++;
			@(posedge i_clk);
		end
		bus_q <= '0;
		chk(n < 100, 1);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(x, e);
	endtask : rdchk

	task automatic cfgw(input logic [31:0] d);
		wr(ADDR_KEY, {24'h00_0000, CCP_KEY});
		wr(ADDR_TMR_CFG, d);
	endtask : cfgw

	// counts stage cycles from the edge that removed the last request until the device runs
	task automatic seq_chk(input int lo);
		int t, s, c, ok;
		t = 0;
		s = 0;
		c = 0;
		ok = 1;
		do begin
			@(negedge i_clk);
			if (osc_start === 1'b1) s++;
			if (osc_cal === 1'b1 && s != SC) ok = 0;
			if (osc_cal === 1'b1) c++;
			t++;
		end while (dev_reset !== 1'b0 && t < 500);
		chk(s, SC);
		chk(c, CC);
		chk(ok, 1);
		chk(t >= lo && t <= BASE + 2, 1);
	endtask : seq_chk

	task automatic wait_run();
		int n;
		n = 0;
		while (dev_reset !== 1'b0 && n < 500) begin
			@(negedge i_clk);
			n++;
		end
		chk(n < 500, 1);
		@(posedge i_clk);
	endtask : wait_run

	// hang guard sized well above the longest timeout run
	initial begin
		#(100 * 60000);
		err_count++;
		complete_run();
	end

	initial begin
		logic [31:0] r;
		logic [3:0] p;
		int n;
		por <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		repeat (2) @(posedge i_clk);
		por <= 1'b0;
		seq_chk(BASE);
		rdchk(ADDR_STATUS, 32'h0000_0001);
		// a new request in mid-sequence must hold reset and restart the stages
		dbg_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		dbg_rst <= 1'b0;
		repeat (DC + 3) @(posedge i_clk);
		drop <= 1'b1;
		// the comparator only counts while the detector is enabled by configuration or forced on
		cfg_en <= 1'b1;
		repeat (4) begin
			@(posedge i_clk);
			@(negedge i_clk);
			chk({dev_reset, osc_start}, 2'b10);
		end
		@(posedge i_clk);
		drop <= 1'b0;
		seq_chk(BASE);
		rdchk(ADDR_STATUS, 32'h0000_0023);
		wr(ADDR_STATUS, 32'h0000_003F);
		rdchk(ADDR_STATUS, 32'h0000_0000);
		// a pin pulse at the minimum length is ignored, a longer one resets
		pin_low <= 1'b1;
		repeat (PC) @(posedge i_clk);
		pin_low <= 1'b0;
		repeat (4) begin
			@(negedge i_clk);
			chk(dev_reset, 1'b0);
		end
		@(posedge i_clk);
		pin_low <= 1'b1;
		repeat (PC + 5) @(posedge i_clk);
		@(negedge i_clk);
		chk(dev_reset, 1'b1);
		@(posedge i_clk);
		pin_low <= 1'b0;
		seq_chk(BASE);
		// software reset: cpu halted at once, reset within two cycles
		wr(ADDR_CTRL, 32'h0000_0001);
		@(negedge i_clk);
		chk(cpu_halt, 1'b1);
		@(negedge i_clk);
		chk({cpu_halt, dev_reset}, 2'b11);
		@(posedge i_clk);
		seq_chk(BASE - 2);
		rdchk(ADDR_STATUS, 32'h0000_0014);
		for (int i = 0; i < 10; i++) begin
			r = xs();
			if (i < 2) r[5:0] = i ? 6'h2F : 6'h0F;
			@(posedge i_clk);
			{cfg_en, erase, dbg_en, fuse} <= r[5:0];
			@(negedge i_clk);
			chk({force_on, thr}, exp_force(r[5:0]));
		end
		// settings refused under the lock fuse and without the key
		@(posedge i_clk);
		lock <= 1'b1;
		cfgw(32'h0000_0001);
		rdchk(ADDR_TMR_CFG, 32'h0000_0000);
		lock <= 1'b0;
		wr(ADDR_TMR_CFG, 32'h0000_0001);
		rdchk(ADDR_TMR_CFG, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			r = xs();
			p = (i == 0) ? 4'h0 : ((i == 1) ? 4'(r % 11) : 4'hA);
			cfgw({24'h00_0000, p, 4'h1});
			rdchk(ADDR_TMR_CFG, {24'h00_0000, p, 4'h1});
			tick_en <= 1'b1;
			n = 0;
			while (dev_reset !== 1'b1 && n < 9000) begin
				@(negedge i_clk);
				n++;
			end
			@(posedge i_clk);
			tick_en <= 1'b0;
			chk(n >= (8 << p) && n <= (8 << p) + 6, 1);
			wait_run();
			cfgw(32'h0000_0000);
		end
		rdchk(ADDR_STATUS, 32'h0000_001C);
		// regular restarts inside the shortest period keep the device running
		cfgw(32'h0000_0001);
		tick_en <= 1'b1;
		repeat (6) begin
			repeat (4) @(posedge i_clk);
			rst_req <= 1'b1;
			@(posedge i_clk);
			rst_req <= 1'b0;
		end
		@(negedge i_clk);
		chk(dev_reset, 1'b0);
		@(posedge i_clk);
		tick_en <= 1'b0;
		// window mode: a restart inside the closed slot resets
		cfgw(32'h0000_0003);
		rst_req <= 1'b1;
		@(posedge i_clk);
		rst_req <= 1'b0;
		n = 0;
		while (dev_reset !== 1'b1 && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		chk(n < 8, 1);
		wait_run();
		// window mode: a restart in the open slot is taken, no restart at all times out
		tick_en <= 1'b1;
		repeat (12) @(posedge i_clk);
		rst_req <= 1'b1;
		@(posedge i_clk);
		rst_req <= 1'b0;
		repeat (4) @(negedge i_clk);
		chk(dev_reset, 1'b0);
		n = 0;
		while (dev_reset !== 1'b1 && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		@(posedge i_clk);
		tick_en <= 1'b0;
		chk(n >= 12 && n <= 20, 1);
		wait_run();
		cfgw(32'h0000_0000);
		rdchk(ADDR_SEQ, 32'h0000_0004);
		rdchk(8'h14, 32'h0000_0000);
		complete_run();
	end
endmodule : rsw_top_test
